// file: sdr_defs.svh
`ifndef SDR_DEFS_SVH
`define SDR_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define SDR_OFS_CTRL        8'h00
`define SDR_OFS_SETPOINT    8'h04
`define SDR_OFS_HYST_OFF    8'h08
`define SDR_OFS_HYST_ON     8'h0c
`define SDR_OFS_GAIN        8'h10
`define SDR_OFS_STATUS      8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define SDR_CTRL_EN_BIT     0
`define SDR_CTRL_SRC_LSB    1
`define SDR_CTRL_SENS_BIT   3
`define SDR_HYST_NONE_BIT   16
`define SDR_SP_TOD_LSB      16
`define SDR_GAIN_KI_LSB     8
`define SDR_GAIN_KD_LSB     16
`define SDR_ST_BURNER_BIT   0
`define SDR_ST_PUMP_BIT     1
`define SDR_ST_SENSDEM_BIT  2
`define SDR_ST_REMOTE_BIT   3
`define SDR_ST_RATE_LSB     16

// ****************************************************************
// Demand source encodings
// ****************************************************************
`define SDR_SRC_LOCAL       2'h0
`define SDR_SRC_REMOTE      2'h1
`define SDR_SRC_LIMIT       2'h2
`define SDR_SRC_SENSOR      2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define SDR_RST_SETPOINT    16'h0000
`define SDR_RST_HYST        16'h0000
`define SDR_RST_GAIN        8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SDR_CLK_PERIOD_NS   4
`define SDR_MSG_TIMEOUT_S   180
`define SDR_MSG_TIMEOUT_CYC \
    (64'd`SDR_MSG_TIMEOUT_S * 64'd1000000000 / 64'd`SDR_CLK_PERIOD_NS)

`endif

// file: sdr_pkg.sv
package sdr_pkg;

    // ****************************************************************
    // Software settings
    // ****************************************************************
    typedef struct packed {
        logic        en;
        logic [1:0]  src;
        logic        sens_sel;
        logic [15:0] sp;
        logic [15:0] sp_tod;
        logic [15:0] hoff;
        logic        hoff_none;
        logic [15:0] hon;
        logic        hon_none;
        logic [7:0]  kp;
        logic [7:0]  ki;
        logic [7:0]  kd;
    } sdr_cfg_t;

    // ****************************************************************
    // Whole module state
    // ****************************************************************
    typedef struct packed {
        sdr_cfg_t           cfg;
        logic               remote_on;
        logic [39:0]        tmo_cnt;
        logic               sens_dem;
        logic               burner;
        logic               pump;
        logic [15:0]        rate;
        logic signed [23:0] integ;
        logic signed [17:0] prev_err;
        logic               wr_pend;
        logic [7:0]         wr_addr;
        logic [31:0]        hrdata;
        logic               hready;
    } sdr_state_t;

endpackage

// file: sdr_steam_demand.sv
`timescale 1ns/1ns
`include "sdr_defs.svh"
module sdr_steam_demand
    import sdr_pkg::*;
#(
    parameter int          PRESS_W     = 16,
    parameter int          PID_SHIFT   = 4,
    parameter logic [39:0] MSG_TMO_CYC = 40'(`SDR_MSG_TIMEOUT_CYC)
)(
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        sys_ce_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic [15:0] outlet_press_in,
    input  wire logic [15:0] inlet_press_in,
    input  wire logic        local_call_in,
    input  wire logic        limit_chain_interlock_in,
    input  wire logic        time_of_day_select_in,
    input  wire logic        remote_msg_valid_in,
    input  wire logic        remote_msg_on_in,
    output logic             burner_demand_out,
    output logic             pump_demand_out,
    output logic      [15:0] mod_rate_out
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    generate
        if (PRESS_W != 16)
        begin : g_bad_w
            $error("sdr_steam_demand: only 16-bit pressures are served");
        end
        if (PID_SHIFT < 0 || PID_SHIFT > 16)
        begin : g_bad_shift
            $error("sdr_steam_demand: PID_SHIFT out of range 0..16");
        end
        if (MSG_TMO_CYC == 40'h0)
        begin : g_bad_tmo
            $error("sdr_steam_demand: message timeout must be nonzero");
        end
    endgenerate

    sdr_state_t         r;
    sdr_state_t         n;
    sdr_state_t         rst_val;

    logic [15:0]        press;
    logic [15:0]        sp_act;
    logic signed [17:0] press_s;
    logic signed [17:0] on_lvl;
    logic signed [17:0] off_lvl;
    logic               gate;
    logic               burner_nxt;
    logic signed [17:0] err;
    logic signed [18:0] deriv;
    logic signed [24:0] integ_sum;
    logic signed [26:0] p_term;
    logic signed [32:0] i_term;
    logic signed [27:0] d_term;
    logic signed [35:0] acc;
    logic signed [35:0] acc_sh;
    logic               addr_ph;
    logic [31:0]        rd_word;

    // ****************************************************************
    // Reset image
    // ****************************************************************
    always_comb
    begin
        rst_val               = '0;
        rst_val.cfg.sp        = `SDR_RST_SETPOINT;
        rst_val.cfg.sp_tod    = `SDR_RST_SETPOINT;
        rst_val.cfg.hoff      = `SDR_RST_HYST;
        rst_val.cfg.hon       = `SDR_RST_HYST;
        rst_val.cfg.kp        = `SDR_RST_GAIN;
        rst_val.cfg.ki        = `SDR_RST_GAIN;
        rst_val.cfg.kd        = `SDR_RST_GAIN;
        rst_val.cfg.src       = `SDR_SRC_SENSOR;
        rst_val.hready        = 1'b1;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        n = r;

        // Sensor and setpoint selection
        press   = r.cfg.sens_sel ? inlet_press_in : outlet_press_in;
        sp_act  = time_of_day_select_in ? r.cfg.sp_tod : r.cfg.sp;
        press_s = $signed({2'b00, press});
        on_lvl  = $signed({2'b00, sp_act})
                - $signed({2'b00, r.cfg.hon_none ? 16'h0000
                                                 : r.cfg.hon});
        off_lvl = $signed({2'b00, sp_act})
                + $signed({2'b00, r.cfg.hoff_none ? 16'h0000
                                                  : r.cfg.hoff});

        // Hysteresis comparator keeps its state between the two levels
        if (press_s < on_lvl)
        begin
            n.sens_dem = 1'b1;
        end
        else if (press_s > off_lvl)
        begin
            n.sens_dem = 1'b0;
        end

        // Remote call state with silence timeout
        if (remote_msg_valid_in)
        begin
            n.remote_on = remote_msg_on_in;
            n.tmo_cnt   = 40'h0;
        end
        else if (r.tmo_cnt >= MSG_TMO_CYC - 40'h1)
        begin
            n.remote_on = 1'b0;
        end
        else
        begin
            n.tmo_cnt = r.tmo_cnt + 40'h1;
        end

        // Demand source gate
        case (r.cfg.src)
            `SDR_SRC_LOCAL:  gate = local_call_in;
            `SDR_SRC_REMOTE: gate = n.remote_on;
            `SDR_SRC_LIMIT:  gate = limit_chain_interlock_in;
            default:         gate = 1'b1;
        endcase

        // Gate is combined directly so a call dropping ends demand at once
        burner_nxt = r.cfg.en & n.sens_dem & gate;
        n.burner   = burner_nxt;
        if (r.cfg.src == `SDR_SRC_SENSOR)
        begin
            n.pump = burner_nxt;
        end
        else
        begin
            n.pump = r.cfg.en & gate;
        end

        // PID on setpoint error; integrator saturates instead of wrapping
        err       = $signed({2'b00, sp_act}) - press_s;
        deriv     = 19'(err) - 19'(r.prev_err);
        integ_sum = 25'(r.integ) + 25'(err);
        p_term    = $signed({1'b0, r.cfg.kp}) * err;
        i_term    = $signed({1'b0, r.cfg.ki}) * r.integ;
        d_term    = $signed({1'b0, r.cfg.kd}) * deriv;
        acc       = 36'(p_term) + 36'(i_term) + 36'(d_term);
        acc_sh    = acc >>> PID_SHIFT;
        if (burner_nxt)
        begin
            if (integ_sum > 25'sh07fffff)
            begin
                n.integ = 24'sh7fffff;
            end
            else if (integ_sum < -25'sh0800000)
            begin
                n.integ = -24'sh800000;
            end
            else
            begin
                n.integ = integ_sum[23:0];
            end
            n.prev_err = err;
            if (acc_sh < 36'sh0)
            begin
                n.rate = 16'h0000;
            end
            else if (acc_sh > 36'sh00000ffff)
            begin
                n.rate = 16'hffff;
            end
            else
            begin
                n.rate = acc_sh[15:0];
            end
        end
        else
        begin
            // No demand: rate idle and loop memory cleared for a clean start
            n.rate     = 16'h0000;
            n.integ    = 24'sh0;
            n.prev_err = 18'sh0;
        end

        // AHB-Lite slave, zero wait states, always OKAY
        addr_ph = hsel_in & hready_in & htrans_in[1];
        rd_word = 32'h0;
        case (haddr_in[7:0])
            `SDR_OFS_CTRL:
            begin
                rd_word[`SDR_CTRL_EN_BIT]                     = r.cfg.en;
                rd_word[`SDR_CTRL_SRC_LSB +: 2]               = r.cfg.src;
                rd_word[`SDR_CTRL_SENS_BIT]                   = r.cfg.sens_sel;
            end
            `SDR_OFS_SETPOINT:
                rd_word = {r.cfg.sp_tod, r.cfg.sp};
            `SDR_OFS_HYST_OFF:
                rd_word = {15'h0000, r.cfg.hoff_none, r.cfg.hoff};
            `SDR_OFS_HYST_ON:
                rd_word = {15'h0000, r.cfg.hon_none, r.cfg.hon};
            `SDR_OFS_GAIN:
                rd_word = {8'h00, r.cfg.kd, r.cfg.ki, r.cfg.kp};
            `SDR_OFS_STATUS:
            begin
                rd_word[`SDR_ST_BURNER_BIT]        = r.burner;
                rd_word[`SDR_ST_PUMP_BIT]          = r.pump;
                rd_word[`SDR_ST_SENSDEM_BIT]       = r.sens_dem;
                rd_word[`SDR_ST_REMOTE_BIT]        = r.remote_on;
                rd_word[`SDR_ST_RATE_LSB +: 16]    = r.rate;
            end
            default:
                rd_word = 32'h0;
        endcase
        if (addr_ph && !hwrite_in)
        begin
            n.hrdata = rd_word;
        end

        // Write data arrives one cycle after its address phase
        if (r.wr_pend)
        begin
            case (r.wr_addr)
                `SDR_OFS_CTRL:
                begin
                    n.cfg.en       = hwdata_in[`SDR_CTRL_EN_BIT];
                    n.cfg.src      = hwdata_in[`SDR_CTRL_SRC_LSB +: 2];
                    n.cfg.sens_sel = hwdata_in[`SDR_CTRL_SENS_BIT];
                end
                `SDR_OFS_SETPOINT:
                begin
                    n.cfg.sp     = hwdata_in[15:0];
                    n.cfg.sp_tod = hwdata_in[`SDR_SP_TOD_LSB +: 16];
                end
                `SDR_OFS_HYST_OFF:
                begin
                    n.cfg.hoff      = hwdata_in[15:0];
                    n.cfg.hoff_none = hwdata_in[`SDR_HYST_NONE_BIT];
                end
                `SDR_OFS_HYST_ON:
                begin
                    n.cfg.hon      = hwdata_in[15:0];
                    n.cfg.hon_none = hwdata_in[`SDR_HYST_NONE_BIT];
                end
                `SDR_OFS_GAIN:
                begin
                    n.cfg.kp = hwdata_in[7:0];
                    n.cfg.ki = hwdata_in[`SDR_GAIN_KI_LSB +: 8];
                    n.cfg.kd = hwdata_in[`SDR_GAIN_KD_LSB +: 8];
                end
                default:
                begin
                    n.cfg = r.cfg;
                end
            endcase
        end
        n.wr_pend = addr_ph & hwrite_in;
        n.wr_addr = haddr_in[7:0];
        n.hready  = 1'b1;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            r <= rst_val;
        end
        else if (sys_ce_in)
        begin
            r <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign hrdata_out        = r.hrdata;
    assign hreadyout_out     = r.hready;
    assign hresp_out         = 1'b0;
    assign burner_demand_out = r.burner;
    assign pump_demand_out   = r.pump;
    assign mod_rate_out      = r.rate;

endmodule // sdr_steam_demand

// file: sdr_steam_demand_props.sv
`timescale 1ns/1ns
module sdr_steam_demand_props #(
    parameter logic [39:0] MSG_TMO_CYC = 40'd50
)(
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic        local_call_in,
    input wire logic        limit_chain_interlock_in,
    input wire logic        remote_msg_valid_in,
    input wire logic        remote_msg_on_in,
    input wire logic        burner_demand_out,
    input wire logic        pump_demand_out,
    input wire logic [15:0] mod_rate_out
);
    // ****************************************************************
    // Shadow of the control word, taken from the bus
    // ****************************************************************
    // Shadow updates on the same edge as the real register
    logic        wr_r;
    logic        en_r;
    logic [1:0]  src_r;
    logic [39:0] idle_r;
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            wr_r   <= 1'b0;
            en_r   <= 1'b0;
            src_r  <= 2'h3;
            idle_r <= 40'h0;
        end
        else
        begin
            wr_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in
                    && haddr_in[7:0] == 8'h00;
            if (wr_r)
            begin
                en_r  <= hwdata_in[0];
                src_r <= hwdata_in[2:1];
            end
            idle_r <= remote_msg_valid_in ? 40'h0 : idle_r + 40'h1;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_rem(logic v);
        en_r && src_r == 2'h1 && remote_msg_valid_in && remote_msg_on_in == v;
    endsequence
    // Receiver gives up on the edge after its silence count reaches MSG_TMO_CYC - 1
    sequence s_quiet;
        en_r && src_r == 2'h1 && !remote_msg_valid_in
        && idle_r >= MSG_TMO_CYC - 40'd1;
    endsequence
    property p_off;
        !en_r |=> !burner_demand_out && !pump_demand_out
                  && mod_rate_out == 16'h0;
    endproperty
    property p_rate;
        !burner_demand_out |-> mod_rate_out == 16'h0;
    endproperty
    property p_sens;
        en_r && src_r == 2'h3 |=> pump_demand_out == burner_demand_out;
    endproperty
    property p_loc;
        en_r && src_r == 2'h0 |=> pump_demand_out == $past(local_call_in)
                                  && (pump_demand_out || !burner_demand_out);
    endproperty
    property p_lim;
        en_r && src_r == 2'h2
        |=> pump_demand_out == $past(limit_chain_interlock_in)
            && (pump_demand_out || !burner_demand_out);
    endproperty
    property p_ron;
        s_rem(1'b1) |=> pump_demand_out;
    endproperty
    property p_roff;
        s_rem(1'b0) |=> !pump_demand_out && !burner_demand_out;
    endproperty
    property p_tmo;
        s_quiet |=> !pump_demand_out && !burner_demand_out;
    endproperty
    a_off: assert property (p_off) else $error("demand while off");
    a_rate: assert property (p_rate) else $error("rate w/o burner");
    a_sens: assert property (p_sens) else $error("pump not burner");
    a_loc: assert property (p_loc) else $error("local call gate");
    a_lim: assert property (p_lim) else $error("interlock gate");
    a_ron: assert property (p_ron) else $error("remote on lost");
    a_roff: assert property (p_roff) else $error("remote off kept");
    a_tmo: assert property (p_tmo) else $error("timeout missed");
endmodule // sdr_steam_demand_props

bind sdr_steam_demand sdr_steam_demand_props #(.MSG_TMO_CYC(MSG_TMO_CYC))
    u_props (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .local_call_in(local_call_in),
    .limit_chain_interlock_in(limit_chain_interlock_in),
    .remote_msg_valid_in(remote_msg_valid_in),
    .remote_msg_on_in(remote_msg_on_in),
    .burner_demand_out(burner_demand_out),
    .pump_demand_out(pump_demand_out), .mod_rate_out(mod_rate_out));

// file: sdr_far_model.sv
`timescale 1ns/1ns
module sdr_far_model #(
    parameter int RESEND = 20
)(
    input  wire logic sys_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic send_in,
    input  wire logic state_in,
    output logic      msg_valid_out,
    output logic      msg_on_out
);
    // ****************************************************************
    // Remote call sender
    // ****************************************************************
    logic [7:0] tick_r;
    logic       fire;
    assign fire = send_in && tick_r == 8'(RESEND - 1);
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            tick_r        <= 8'h0;
            msg_valid_out <= 1'b0;
            msg_on_out    <= 1'b0;
        end
        else
        begin
            tick_r        <= (fire || !send_in) ? 8'h0 : tick_r + 8'h1;
            // Resent well inside the receiver timeout
            msg_valid_out <= fire;
            // Between messages the state line means nothing: keep it moving
            msg_on_out    <= fire ? state_in : ~msg_on_out;
        end
    end
endmodule // sdr_far_model

// file: sdr_steam_demand_tb.sv
`timescale 1ns/1ns
module sdr_steam_demand_tb;
    // ****************************************************************
    // Stimulus and scoreboard
    // ****************************************************************
    typedef struct {
        logic        kind;
        logic [31:0] exp;
        logic [31:0] mask;
    } sdr_note_t;
    localparam logic [15:0] PT [5] = '{16'h03b6, 16'h0383, 16'h041a,
                                       16'h041b, 16'h03e8};
    localparam logic [4:0]  DB = 5'b00110;
    sdr_note_t   notes[$];
    event        go;
    int          fails = 0;
    int          cmp_count = 0;
    int          seed = 32'hd7f5;
    logic        sys_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd_q;
    logic [31:0] hrdata;
    logic [15:0] outlet = 16'h044c;
    logic [15:0] inlet = 16'h0;
    logic [15:0] rate;
    logic        call = 1'b0;
    logic        lim = 1'b0;
    logic        time_of_day_select = 1'b0;
    logic        send = 1'b0;
    logic        state = 1'b0;
    logic        mv, mon, hrdy, burner, pump;
    logic        hresp;

    initial forever #2 sys_clk_in = ~sys_clk_in;

    sdr_far_model u_far (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .send_in(send), .state_in(state), .msg_valid_out(mv),
        .msg_on_out(mon));
    sdr_steam_demand #(.MSG_TMO_CYC(40'd50)) dut (.sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in), .sys_ce_in(1'b1), .hsel_in(1'b1),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .outlet_press_in(outlet), .inlet_press_in(inlet),
        .local_call_in(call), .limit_chain_interlock_in(lim),
        .time_of_day_select_in(time_of_day_select), .remote_msg_valid_in(mv),
        .remote_msg_on_in(mon), .burner_demand_out(burner),
        .pump_demand_out(pump), .mod_rate_out(rate));

    task automatic summarize;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge sys_clk_in);
        while (hrdy !== 1'b1 && n < 64)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 64)
        begin
            fails++;
            summarize();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd_q = hrdata;
        cmp_count++;
        if (hresp !== 1'b0)
        begin
            $display("ERROR hresp expected 0 seen %b", hresp);
            fails++;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        notes.push_back('{1'b1, e, 32'hffffffff});
        -> go;
    endtask

    // Rate under demand is left free unless an expected rate is given
    task automatic dem(input logic b, input logic p,
                       input logic [15:0] rt = 16'h0000);
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        notes.push_back('{1'b0, {rt, 14'h0, p, b},
                          (b && rt == 16'h0000) ? 32'h3 : 32'hffff0003});
        -> go;
        @(posedge sys_clk_in);
    endtask

    task automatic gate(input logic s, input logic v);
        if (s)
            lim <= v;
        else
            call <= v;
    endtask

    always @(go)
    begin
        sdr_note_t   nt;
        logic [31:0] seen;
        nt = notes.pop_front();
        seen = nt.kind ? rd_q : {rate, 14'h0, pump, burner};
        cmp_count++;
        if ((seen & nt.mask) !== (nt.exp & nt.mask))
        begin
            $display("ERROR %s expected %h seen %h",
                     nt.kind ? "hrdata" : "demand", nt.exp & nt.mask,
                     seen & nt.mask);
            fails++;
        end
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        fails++;
        summarize();
    end

    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rd(8'h00, 32'h6);
        rd(8'h0c, 32'h0);
        bus(1'b1, 8'h04, 32'h07d003e8);
        bus(1'b1, 8'h08, 32'h32);
        bus(1'b1, 8'h0c, 32'h64);
        bus(1'b1, 8'h10, 32'h010101);
        bus(1'b1, 8'h14, 32'hffffffff);
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h04, 32'h07d003e8);
        bus(1'b1, 8'h00, 32'h7);
        for (int i = 0; i < 5; i++)
        begin
            outlet <= PT[i];
            dem(DB[i], DB[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            outlet <= 16'h0064 + (16'($random(seed)) & 16'h01ff);
            dem(1'b1, 1'b1);
            outlet <= 16'h041b + (16'($random(seed)) & 16'h03ff);
            dem(1'b0, 1'b0);
        end
        time_of_day_select <= 1'b1;
        outlet <= 16'h0708;
        dem(1'b1, 1'b1);
        time_of_day_select <= 1'b0;
        dem(1'b0, 1'b0);
        outlet <= 16'h03e8;
        bus(1'b1, 8'h0c, 32'h00010064);
        dem(1'b0, 1'b0);
        outlet <= 16'h03e7;
        dem(1'b1, 1'b1);
        outlet <= 16'h03e9;
        dem(1'b1, 1'b1);
        bus(1'b1, 8'h08, 32'h00010032);
        dem(1'b0, 1'b0);
        outlet <= 16'h07d0;
        inlet <= 16'h01f4;
        bus(1'b1, 8'h00, 32'hf);
        dem(1'b1, 1'b1);
        bus(1'b1, 8'h00, 32'h7);
        dem(1'b0, 1'b0);
        outlet <= 16'h01f4;
        bus(1'b1, 8'h00, 32'h6);
        dem(1'b0, 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            bus(1'b1, 8'h00, s ? 32'h5 : 32'h1);
            dem(1'b0, 1'b0);
            gate(s[0], 1'b1);
            dem(1'b1, 1'b1, 16'h003e);
            outlet <= 16'h044c;
            dem(1'b0, 1'b1);
            outlet <= 16'h01f4;
            dem(1'b1, 1'b1);
            gate(s[0], 1'b0);
            dem(1'b0, 1'b0);
        end
        state <= 1'b1;
        send <= 1'b1;
        bus(1'b1, 8'h00, 32'h3);
        repeat (24) @(posedge sys_clk_in);
        dem(1'b1, 1'b1);
        state <= 1'b0;
        repeat (24) @(posedge sys_clk_in);
        dem(1'b0, 1'b0);
        state <= 1'b1;
        repeat (24) @(posedge sys_clk_in);
        dem(1'b1, 1'b1);
        send <= 1'b0;
        repeat (24) @(posedge sys_clk_in);
        dem(1'b1, 1'b1);
        repeat (34) @(posedge sys_clk_in);
        dem(1'b0, 1'b0);
        summarize();
    end
endmodule // sdr_steam_demand_tb
